// file: common/fcm_consts.svh
// Constants for the fieldbus function code mapper: offsets, field positions, defaults and timing.
`ifndef FCM_CONSTS_SVH
`define FCM_CONSTS_SVH
`define FCM_ASM_OUT 16'h0064
`define FCM_ASM_IN 16'h0096
`define FCM_IO_WORDS 16'h0020
`define FCM_ALIAS_FIRST 16'h1389
`define FCM_ALIAS_LAST 16'h13BA
`define FCM_TMO_PAIRS 4'hA
`define FCM_CONS_BASE 7'h00
`define FCM_PROD_BASE 7'h20
`define FCM_ALIAS_BASE 7'h40
`define FCM_TMO_BASE 7'h72
`define FCM_ENTRIES 7'h7C
`define FCM_E_VALID 32
`define FCM_E_CODE_HI 31
`define FCM_E_CODE_LO 16
`define FCM_E_VAL_HI 15
`define FCM_E_VAL_LO 0
`define FCM_REG_CMD 16'h0707
`define FCM_REG_FREQ 16'h0706
`define FCM_REG_OUTF 16'h080A
`define FCM_REG_STAT 16'h080F
`define FCM_REG_DCV 16'h0816
`define FCM_TMO_DEFAULT_S 10
`define FCM_TMO_DEFAULT_MS (`FCM_TMO_DEFAULT_S * 1000)
`define FCM_CLK_MHZ 100
`define FCM_CYC_PER_MS (`FCM_CLK_MHZ * 1000)
`endif

// file: common/fcm_pkg.sv
// Types shared by the fieldbus function code mapper.
package fcm_pkg;
    typedef enum logic [2:0] {
        k_cons_wr,
        k_prod_rd,
        k_alias_rd,
        k_alias_wr,
        k_native_rd,
        k_native_wr
    } fcm_kind_t;
    typedef enum logic [1:0] {
        tab_cons,
        tab_prod,
        tab_alias,
        tab_tmo
    } fcm_tab_t;
    typedef enum logic [2:0] {
        st_load,
        st_idle,
        st_look,
        st_fwd,
        st_fs_look,
        st_fs_fwd
    } fcm_state_t;
    typedef logic [32:0] fcm_entry_t;
endpackage

// file: dv/fcm_inv_model.sv
// Inverter function code space answering the mapper's back-end port.
`timescale 1ns/1ps
module fcm_inv_model (
    // Clock, reset and pace
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic slow_i,
    // Back-end port
    input wire logic req_i,
    input wire logic we_i,
    input wire logic [15:0] addr_i,
    input wire logic [15:0] wdata_i,
    output logic ack_o,
    output logic [15:0] rdata_o
);
    logic [15:0] mem [int];
    int cnt = 0;
    always @(posedge clk_i) begin
        if (!reset_i && req_i && ack_o !== 1'b1 && cnt >= (slow_i ? 5 : 0)) begin
            ack_o <= #1 1'b1;
            rdata_o <= #1 mem.exists(addr_i) ? mem[addr_i] : addr_i ^ 16'hA5C3;
            cnt <= #1 0;
            if (we_i) mem[addr_i] = wdata_i;
        end else begin
            ack_o <= #1 1'b0;
            rdata_o <= #1 reset_i ? 16'h0000 : ~rdata_o;
            cnt <= #1 (!reset_i && req_i && ack_o !== 1'b1) ? cnt + 1 : 0;
        end
    end
endmodule

// file: dv/fcm_mapper_tb.sv
// Self-checking bench for the function code mapper against a reference model.
`timescale 1ns/1ps
module fcm_mapper_tb
    import fcm_pkg::*;
();
    logic clk_i = 1'b0, reset_i = 1'b1, io_conn_open_i = 1'b0, req_valid_i = 1'b0, cfg_valid_i = 1'b0;
    logic cfg_clear_i = 1'b0, tmo_event_i = 1'b0, store_blank_i = 1'b1, sup_en_i = 1'b0, slow_i = 1'b0, act = 1'b0;
    logic [15:0] io_asm_out_i = '0, io_asm_in_i = '0, req_index_i = '0, req_wdata_i = '0, cfg_code_i = '0;
    logic [15:0] cfg_value_i = '0, resp_data_o, inv_addr_o, inv_wdata_o, inv_rdata_i;
    logic [5:0] cfg_index_i = '0;
    logic [6:0] store_addr_o;
    logic [31:0] tmo_ms_i = '0, rs = 32'hDB787FE9;
    fcm_kind_t req_kind_i = k_cons_wr;
    fcm_tab_t cfg_sel_i = tab_cons;
    fcm_entry_t store_rdata_i = '0;
    logic map_active_o, req_ready_o, resp_valid_o, resp_hit_o, cfg_ready_o, cfg_err_o, store_rd_o, load_busy_o;
    logic tmo_fire_o, inv_req_o, inv_we_o, inv_ack_i;
    fcm_entry_t stor [124];
    logic [15:0] inv_m [int];
    logic [15:0] al [5] = '{16'h0707, 16'h0706, 16'h080A, 16'h0816, 16'h080F};
    int tab [4][64];
    int tv [10];
    int n_fail = 0, total_checks = 0, cyc = 0, fires = 0;

    fcm_mapper #(.CYC_PER_MS(4)) fcm_mapper_inst (.*);
    fcm_inv_model fcm_inv_model_inst (.clk_i(clk_i), .reset_i(reset_i), .slow_i(slow_i), .req_i(inv_req_o),
        .we_i(inv_we_o), .addr_i(inv_addr_o), .wdata_i(inv_wdata_o), .ack_o(inv_ack_i), .rdata_o(inv_rdata_i));

    always #5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (tmo_fire_o === 1'b1) fires <= fires + 1;
        if (store_rd_o === 1'b1) store_rdata_i <= #1 stor[store_addr_o];
        if (cyc == 60000) begin
            n_fail = n_fail + 1;
            complete_run();
        end
    end
////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction
    function automatic logic [15:0] inv_rd(int a);
        return inv_m.exists(a) ? inv_m[a] : a[15:0] ^ 16'hA5C3;
    endfunction
    task automatic check(logic [31:0] s, logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            n_fail++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, s, e);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic step();
        @(posedge clk_i);
        #1;
    endtask
    task automatic access(fcm_kind_t k, logic [15:0] x, logic [15:0] wd = 16'h0000);
        int c;
        logic rd;
        rd = k inside {k_prod_rd, k_alias_rd, k_native_rd};
        c = k > k_alias_wr ? x : k > k_prod_rd ? (x > 16'h1388 && x < 16'h13BB ? tab[2][x - 16'h1389] : 0)
            : (act && x < 32 ? tab[k][x] : 0);
        step();
        req_valid_i = 1'b1;
        req_kind_i = k;
        req_index_i = x;
        req_wdata_i = wd;
        while (req_ready_o !== 1'b1) step();
        step();
        req_valid_i = 1'b0;
        while (resp_valid_o !== 1'b1) step();
        check(resp_hit_o, c != 0);
        check(resp_data_o, rd && c != 0 ? inv_rd(c) : 16'h0000);
        if (!rd && c != 0) inv_m[c] = wd;
    endtask
    task automatic cfg(fcm_tab_t s, logic [5:0] i, logic [15:0] code, logic [15:0] v = 16'h0000, logic clr = 1'b0);
        logic e;
        logic bad;
        bad = !clr && (code == 0 || (code > 16'h1388 && code < 16'h13BB));
        e = i >= (s == tab_tmo ? 10 : s == tab_alias ? 50 : 32) || bad;
        tab[s][i] = bad || clr ? 0 : code;
        if (s == tab_tmo && i < 10) tv[i] = v;
        step();
        cfg_valid_i = 1'b1;
        cfg_sel_i = s;
        cfg_index_i = i;
        cfg_code_i = code;
        cfg_value_i = v;
        cfg_clear_i = clr;
        while (cfg_ready_o !== 1'b1) step();
        step();
        cfg_valid_i = 1'b0;
        bad = cfg_err_o === 1'b1;
        step();
        check(bad || cfg_err_o === 1'b1, e);
    endtask
    task automatic expect_fire(int w, int n);
        int f0;
        f0 = fires;
        repeat (w) step();
        check(fires - f0, n);
        for (int i = 0; i < 10 && n > 0; i++) if (tab[3][i] != 0) inv_m[tab[3][i]] = tv[i][15:0];
    endtask
    task automatic do_reset();
        int b;
        reset_i = 1'b1;
        tab = '{default: 0};
        for (int i = 0; i < 114; i++) begin
            b = i < 64 ? i / 32 : 2;
            if (!store_blank_i && stor[i][32]) tab[b][i - b * 32] = stor[i][31:16];
        end
        if (store_blank_i) begin
            tab[0][0] = 16'h0707;
            tab[0][1] = 16'h0706;
            tab[1][0] = 16'h080F;
            tab[1][1] = 16'h080A;
        end
        repeat (8) @(posedge clk_i);
        #1 reset_i = 1'b0;
        check(req_ready_o, 1'b0);
        while (load_busy_o !== 1'b0) step();
    endtask
////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] r;
        fcm_kind_t k;
        stor = '{default: '0};
        do_reset();
        for (int t = 0; t < 4; t++) begin
            io_conn_open_i = t != 0;
            io_asm_out_i = t == 1 ? 16'h0096 : 16'h0064;
            io_asm_in_i = t == 2 ? 16'h0097 : 16'h0096;
            act = t == 3;
            step();
            step();
            check(map_active_o, act);
            access(k_prod_rd, 16'h0000);
        end
        access(k_prod_rd, 16'h0001);
        access(k_cons_wr, 16'h0000, 16'h0047);
        access(k_cons_wr, 16'h0001, 16'h07D0);
        access(k_native_rd, 16'h0706);
        access(k_cons_wr, 16'h0002, 16'h1111);
        access(k_prod_rd, 16'h0025);
        cfg(tab_cons, 6'h1F, 16'h0300);
        cfg(tab_cons, 6'h20, 16'h0300);
        cfg(tab_prod, 6'h05, 16'h0000);
        cfg(tab_alias, 6'h09, 16'h1389);
        cfg(tab_alias, 6'h32, 16'h0707);
        cfg(tab_alias, 6'h31, 16'h0300);
        cfg(tab_tmo, 6'h0A, 16'h0706);
        cfg(tab_tmo, 6'h00, 16'h0706, 16'h07D0);
        cfg(tab_tmo, 6'h09, 16'h0300, 16'h1234);
        for (int i = 0; i < 5; i++) cfg(tab_alias, i[5:0], al[i]);
        for (int a = 16'h138B; a < 16'h138E; a++) access(k_alias_rd, a[15:0]);
        for (int a = 16'h1389; a < 16'h138B; a++) access(k_alias_wr, a[15:0], 16'(rnd()));
        access(k_native_rd, 16'h0707);
        cfg(tab_alias, 6'h04, 16'h0000, 16'h0000, 1'b1);
        for (int t = 0; t < 80; t++) begin
            r = rnd();
            slow_i = r[3];
            k = fcm_kind_t'(r[6:4] % 3'h6);
            access(k, k < k_alias_rd ? 16'(r[21:16] % 6'h28) : k < k_native_rd ? 16'h1388 + 16'(r[21:16])
                : al[r[18:16] % 3'h5], r[31:16]);
        end
        tmo_event_i = 1'b1;
        step();
        tmo_event_i = 1'b0;
        expect_fire(40, 1);
        access(k_native_rd, 16'h0706);
        access(k_native_rd, 16'h0300);
        slow_i = 1'b1;
        tmo_ms_i = 32'h0000_0002;
        sup_en_i = 1'b1;
        expect_fire(80, 1);
        sup_en_i = 1'b0;
        tmo_ms_i = '0;
        access(k_alias_rd, 16'h138A);
        sup_en_i = 1'b1;
        expect_fire(39900, 0);
        expect_fire(300, 1);
        sup_en_i = 1'b0;
        stor[7'h42] = {1'b1, 16'h080A, 16'h0000};
        store_blank_i = 1'b0;
        do_reset();
        access(k_alias_rd, 16'h138B);
        access(k_alias_rd, 16'h1389);
        access(k_prod_rd, 16'h0000);
        complete_run();
    end
endmodule

// file: rtl/fcm_mapper.sv
// Fieldbus function code mapper: cyclic I/O tables, alias window, fail-safe timeout writes.
`timescale 1ns/1ps
`include "fcm_consts.svh"
module fcm_mapper
    import fcm_pkg::*;
#(
    parameter int CYC_PER_MS = `FCM_CYC_PER_MS
)(
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Cyclic connection
    input wire logic io_conn_open_i,
    input wire logic [15:0] io_asm_out_i,
    input wire logic [15:0] io_asm_in_i,
    output logic map_active_o,
    // Word requests
    input wire logic req_valid_i,
    output logic req_ready_o,
    input wire fcm_kind_t req_kind_i,
    input wire logic [15:0] req_index_i,
    input wire logic [15:0] req_wdata_i,
    output logic resp_valid_o,
    output logic [15:0] resp_data_o,
    output logic resp_hit_o,
    // Configuration
    input wire logic cfg_valid_i,
    output logic cfg_ready_o,
    input wire fcm_tab_t cfg_sel_i,
    input wire logic [5:0] cfg_index_i,
    input wire logic cfg_clear_i,
    input wire logic [15:0] cfg_code_i,
    input wire logic [15:0] cfg_value_i,
    output logic cfg_err_o,
    // Stored configuration
    output logic store_rd_o,
    output logic [6:0] store_addr_o,
    input wire logic store_blank_i,
    input wire fcm_entry_t store_rdata_i,
    output logic load_busy_o,
    // Timeout
    input wire logic sup_en_i,
    input wire logic [31:0] tmo_ms_i,
    input wire logic tmo_event_i,
    output logic tmo_fire_o,
    // Inverter function code port
    output logic inv_req_o,
    output logic inv_we_o,
    output logic [15:0] inv_addr_o,
    output logic [15:0] inv_wdata_o,
    input wire logic inv_ack_i,
    input wire logic [15:0] inv_rdata_i
);
    ////////////////////////////////////////////////////////////////////////////////////////////////
    fcm_state_t state_q, state_d;
    fcm_entry_t mem_rdata, mem_wdata;
    logic mem_we;
    logic [6:0] mem_addr, look_addr, cfg_addr;
    logic [6:0] ld_idx_q, ld_prev_q;
    logic ld_pend_q;
    logic map_active_q;
    logic req_take, cfg_take, look_range, look_direct, cfg_code_ok, cfg_idx_ok;
    logic range_q, direct_q, we_q, io_kind_q, hit;
    logic [15:0] idx_q, wdata_q, alias_off;
    logic fs_pend_q, fs_step, fs_done, sup_fire;
    logic [3:0] fs_idx_q;
    logic [16:0] ms_cnt_q;
    logic [31:0] ms_q, limit_ms;
    logic armed_q, tick;
    logic inv_req_q, inv_we_q, resp_valid_q, resp_hit_q, cfg_err_q, tmo_fire_q;
    logic [15:0] inv_addr_q, inv_wdata_q, resp_data_q;

    function automatic fcm_entry_t def_entry(input logic [6:0] a);
        fcm_entry_t e;
        e = 33'h0_0000_0000;
        if (a == `FCM_CONS_BASE) e = {1'b1, `FCM_REG_CMD, 16'h0000};
        if (a == `FCM_CONS_BASE + 7'h01) e = {1'b1, `FCM_REG_FREQ, 16'h0000};
        if (a == `FCM_PROD_BASE) e = {1'b1, `FCM_REG_STAT, 16'h0000};
        if (a == `FCM_PROD_BASE + 7'h01) e = {1'b1, `FCM_REG_OUTF, 16'h0000};
        return e;
    endfunction

    fcm_table_mem u_mem (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .we_i(mem_we),
        .addr_i(mem_addr),
        .wdata_i(mem_wdata),
        .rdata_o(mem_rdata)
    );

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Request decode and table addressing.
    assign cfg_ready_o = (state_q == st_idle) && !fs_pend_q;
    assign req_ready_o = cfg_ready_o && !cfg_valid_i;
    assign req_take = req_valid_i && req_ready_o;
    assign cfg_take = cfg_valid_i && cfg_ready_o;
    assign alias_off = req_index_i - `FCM_ALIAS_FIRST;
    assign look_direct = (req_kind_i == k_native_rd) || (req_kind_i == k_native_wr);

    always_comb begin
        look_range = 1'b0;
        look_addr = `FCM_CONS_BASE;
        unique case (req_kind_i)
            k_cons_wr: begin
                look_range = req_index_i < `FCM_IO_WORDS;
                look_addr = `FCM_CONS_BASE + {2'b00, req_index_i[4:0]};
            end
            k_prod_rd: begin
                look_range = req_index_i < `FCM_IO_WORDS;
                look_addr = `FCM_PROD_BASE + {2'b00, req_index_i[4:0]};
            end
            k_alias_rd, k_alias_wr: begin
                look_range = (req_index_i >= `FCM_ALIAS_FIRST) && (req_index_i <= `FCM_ALIAS_LAST);
                look_addr = `FCM_ALIAS_BASE + alias_off[6:0];
            end
            k_native_rd, k_native_wr: begin
                look_range = 1'b1;
            end
        endcase
    end

    always_comb begin
        cfg_idx_ok = 1'b0;
        cfg_addr = `FCM_CONS_BASE;
        unique case (cfg_sel_i)
            tab_cons: begin
                cfg_idx_ok = cfg_index_i < 6'h20;
                cfg_addr = `FCM_CONS_BASE + {2'b00, cfg_index_i[4:0]};
            end
            tab_prod: begin
                cfg_idx_ok = cfg_index_i < 6'h20;
                cfg_addr = `FCM_PROD_BASE + {2'b00, cfg_index_i[4:0]};
            end
            tab_alias: begin
                cfg_idx_ok = cfg_index_i < 6'h32;
                cfg_addr = `FCM_ALIAS_BASE + {1'b0, cfg_index_i};
            end
            tab_tmo: begin
                cfg_idx_ok = cfg_index_i < {2'b00, `FCM_TMO_PAIRS};
                cfg_addr = `FCM_TMO_BASE + {1'b0, cfg_index_i};
            end
        endcase
    end

    // A target must be a native register: nonzero and outside the alias window.
    assign cfg_code_ok = (cfg_code_i != 16'h0000) && ((cfg_code_i < `FCM_ALIAS_FIRST) || (cfg_code_i > `FCM_ALIAS_LAST));

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Table memory port.
    always_comb begin
        mem_we = 1'b0;
        mem_addr = look_addr;
        mem_wdata = 33'h0_0000_0000;
        if (state_q == st_load) begin
            mem_we = ld_pend_q;
            mem_addr = ld_prev_q;
            mem_wdata = store_blank_i ? def_entry(ld_prev_q) : store_rdata_i;
        end else if (cfg_take) begin
            mem_we = cfg_idx_ok;
            mem_addr = cfg_addr;
            mem_wdata = (cfg_code_ok && !cfg_clear_i) ? {1'b1, cfg_code_i, cfg_value_i} : 33'h0_0000_0000;
        end else if (state_q == st_idle && fs_pend_q) begin
            mem_addr = `FCM_TMO_BASE + {3'b000, fs_idx_q};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Load from stored configuration.
    assign store_rd_o = (state_q == st_load) && (ld_idx_q < `FCM_ENTRIES);
    assign store_addr_o = ld_idx_q;
    assign load_busy_o = (state_q == st_load);

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ld_idx_q <= 7'h00;
            ld_prev_q <= 7'h00;
            ld_pend_q <= 1'b0;
        end else begin
            ld_pend_q <= store_rd_o;
            ld_prev_q <= ld_idx_q;
            if (store_rd_o) begin
                ld_idx_q <= ld_idx_q + 7'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Sequencer.
    assign hit = direct_q || (range_q && mem_rdata[`FCM_E_VALID] && (!io_kind_q || map_active_q));
    assign fs_step = (state_q == st_fs_look && !mem_rdata[`FCM_E_VALID]) || (state_q == st_fs_fwd && inv_ack_i);
    assign fs_done = fs_step && (fs_idx_q == `FCM_TMO_PAIRS - 4'h1);

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            st_load: if (ld_pend_q && ld_prev_q == `FCM_ENTRIES - 7'h01) state_d = st_idle;
            st_idle: begin
                if (fs_pend_q) state_d = st_fs_look;
                else if (req_take) state_d = st_look;
            end
            st_look: state_d = hit ? st_fwd : st_idle;
            st_fwd: if (inv_ack_i) state_d = st_idle;
            st_fs_look: state_d = mem_rdata[`FCM_E_VALID] ? st_fs_fwd : st_idle;
            st_fs_fwd: if (inv_ack_i) state_d = st_idle;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_q <= st_load;
        end else begin
            state_q <= state_d;
        end
    end

    // Each accepted word is served alone, so multi-register transfers keep their issue order.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            range_q <= 1'b0;
            direct_q <= 1'b0;
            we_q <= 1'b0;
            io_kind_q <= 1'b0;
            idx_q <= 16'h0000;
            wdata_q <= 16'h0000;
        end else if (req_take) begin
            range_q <= look_range;
            direct_q <= look_direct;
            we_q <= (req_kind_i == k_cons_wr) || (req_kind_i == k_alias_wr) || (req_kind_i == k_native_wr);
            io_kind_q <= (req_kind_i == k_cons_wr) || (req_kind_i == k_prod_rd);
            idx_q <= req_index_i;
            wdata_q <= req_wdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            map_active_q <= 1'b0;
        end else begin
            map_active_q <= io_conn_open_i && io_asm_out_i == `FCM_ASM_OUT && io_asm_in_i == `FCM_ASM_IN;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Inverter port.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            inv_req_q <= 1'b0;
            inv_we_q <= 1'b0;
            inv_addr_q <= 16'h0000;
            inv_wdata_q <= 16'h0000;
        end else if (state_q == st_look && hit) begin
            inv_req_q <= 1'b1;
            inv_we_q <= we_q;
            inv_addr_q <= direct_q ? idx_q : mem_rdata[`FCM_E_CODE_HI:`FCM_E_CODE_LO];
            inv_wdata_q <= wdata_q;
        end else if (state_q == st_fs_look && mem_rdata[`FCM_E_VALID]) begin
            inv_req_q <= 1'b1;
            inv_we_q <= 1'b1;
            inv_addr_q <= mem_rdata[`FCM_E_CODE_HI:`FCM_E_CODE_LO];
            inv_wdata_q <= mem_rdata[`FCM_E_VAL_HI:`FCM_E_VAL_LO];
        end else if (inv_ack_i) begin
            inv_req_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Response.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            resp_valid_q <= 1'b0;
            resp_hit_q <= 1'b0;
            resp_data_q <= 16'h0000;
        end else begin
            resp_valid_q <= 1'b0;
            if (state_q == st_look && !hit) begin
                resp_valid_q <= 1'b1;
                resp_hit_q <= 1'b0;
                resp_data_q <= 16'h0000;
            end else if (state_q == st_fwd && inv_ack_i) begin
                resp_valid_q <= 1'b1;
                resp_hit_q <= 1'b1;
                resp_data_q <= we_q ? 16'h0000 : inv_rdata_i;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cfg_err_q <= 1'b0;
        end else begin
            cfg_err_q <= cfg_take && (!cfg_idx_ok || (!cfg_clear_i && !cfg_code_ok));
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Supervisory timer and fail-safe walk.
    assign limit_ms = (tmo_ms_i == 32'h0000_0000) ? 32'(`FCM_TMO_DEFAULT_MS) : tmo_ms_i;
    assign tick = (ms_cnt_q == 17'(CYC_PER_MS - 1));
    assign sup_fire = sup_en_i && armed_q && tick && (ms_q >= limit_ms - 32'h0000_0001);

    // Activity is any alias or native access; connection open or closed does not matter.
    always_ff @(posedge clk_i) begin
        if (reset_i || !sup_en_i || (req_take && !look_direct && req_kind_i != k_alias_rd &&
                                     req_kind_i != k_alias_wr)) begin
            ms_cnt_q <= ms_cnt_q;
        end
        if (reset_i || !sup_en_i || (req_take && (look_direct || req_kind_i == k_alias_rd ||
                                                  req_kind_i == k_alias_wr))) begin
            ms_cnt_q <= 17'h0_0000;
            ms_q <= 32'h0000_0000;
            armed_q <= 1'b1;
        end else begin
            ms_cnt_q <= tick ? 17'h0_0000 : ms_cnt_q + 17'h0_0001;
            if (tick && armed_q) begin
                ms_q <= ms_q + 32'h0000_0001;
            end
            if (sup_fire) begin
                armed_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            tmo_fire_q <= 1'b0;
            fs_pend_q <= 1'b0;
            fs_idx_q <= 4'h0;
        end else begin
            tmo_fire_q <= sup_fire || tmo_event_i;
            fs_pend_q <= tmo_fire_q || (fs_pend_q && !fs_done);
            if (fs_step) begin
                fs_idx_q <= fs_done ? 4'h0 : fs_idx_q + 4'h1;
            end
        end
    end

    assign map_active_o = map_active_q;
    assign resp_valid_o = resp_valid_q;
    assign resp_data_o = resp_data_q;
    assign resp_hit_o = resp_hit_q;
    assign cfg_err_o = cfg_err_q;
    assign tmo_fire_o = tmo_fire_q;
    assign inv_req_o = inv_req_q;
    assign inv_we_o = inv_we_q;
    assign inv_addr_o = inv_addr_q;
    assign inv_wdata_o = inv_wdata_q;

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Checks.
    property p_io_gate;
        @(posedge clk_i) disable iff (reset_i)
        (state_q == st_fwd && io_kind_q) |-> map_active_q || $past(map_active_q);
    endproperty
    a_io_gate: assert property (p_io_gate) else $error("cyclic word forwarded without user mapping");

    property p_empty_zero;
        @(posedge clk_i) disable iff (reset_i)
        (resp_valid_o && !resp_hit_o) |-> resp_data_o == 16'h0000 && !inv_req_o;
    endproperty
    a_empty_zero: assert property (p_empty_zero) else $error("unmapped word returned nonzero");

    property p_range;
        @(posedge clk_i) disable iff (reset_i)
        (req_take && req_kind_i == k_prod_rd && req_index_i >= `FCM_IO_WORDS) |=> ##1 resp_valid_o && !resp_hit_o;
    endproperty
    a_range: assert property (p_range) else $error("word past table not answered with zero");

    property p_bad_code;
        @(posedge clk_i) disable iff (reset_i)
        (cfg_take && !cfg_clear_i && !cfg_code_ok) |=> cfg_err_o;
    endproperty
    a_bad_code: assert property (p_bad_code) else $error("invalid code not flagged");

    property p_load_first;
        @(posedge clk_i) disable iff (reset_i)
        load_busy_o |-> !req_ready_o && !cfg_ready_o && !inv_req_o;
    endproperty
    a_load_first: assert property (p_load_first) else $error("access served during load");

    property p_fs_pairs;
        @(posedge clk_i) disable iff (reset_i)
        fs_idx_q < `FCM_TMO_PAIRS;
    endproperty
    a_fs_pairs: assert property (p_fs_pairs) else $error("fail-safe walk past last pair");

    property p_fire;
        @(posedge clk_i) disable iff (reset_i)
        sup_fire |=> tmo_fire_o ##1 fs_pend_q;
    endproperty
    a_fire: assert property (p_fire) else $error("supervisory timeout did not start fail-safe");

    property p_native;
        @(posedge clk_i) disable iff (reset_i)
        (state_q == st_look && direct_q) |=> inv_req_o && inv_addr_o == $past(idx_q);
    endproperty
    a_native: assert property (p_native) else $error("native access redirected");

    property p_hold;
        @(posedge clk_i) disable iff (reset_i)
        (inv_req_o && !inv_ack_i) |=> inv_req_o && $stable(inv_addr_o);
    endproperty
    a_hold: assert property (p_hold) else $error("inverter request dropped before ack");

    c_alias_hit: cover property (@(posedge clk_i) disable iff (reset_i)
        state_q == st_look && range_q && !direct_q && !io_kind_q && hit);
    c_io_hit: cover property (@(posedge clk_i) disable iff (reset_i) state_q == st_look && io_kind_q && hit);
    c_fs_write: cover property (@(posedge clk_i) disable iff (reset_i) state_q == st_fs_fwd && inv_ack_i);
    c_cfg_err: cover property (@(posedge clk_i) disable iff (reset_i) cfg_err_o);
endmodule

// file: rtl/fcm_table_mem.sv
// Single-port table memory with a registered read port.
`timescale 1ns/1ps
module fcm_table_mem
    import fcm_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Access port
    input wire logic we_i,
    input wire logic [6:0] addr_i,
    input wire fcm_entry_t wdata_i,
    output fcm_entry_t rdata_o
);
    fcm_entry_t mem [0:127];
    fcm_entry_t rdata_q;

    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[addr_i] <= wdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rdata_q <= 33'h0_0000_0000;
        end else begin
            rdata_q <= mem[addr_i];
        end
    end

    assign rdata_o = rdata_q;
endmodule
